// File: verilog/trc_ctrl.sv
/*
 * trc_ctrl: control register, horizontal reference select, flicker filter
 * mode and frame-sync driven encoder timing reset.
 * assumes one pixel clock; the frame sync and field parity come from
 * the graphics display controller and are resynchronised here.
 */
// Function
// - filter code 00 applies weights 1/4, 1/2, 1/4
// - filter code 01 applies weights 1/2, 1, 1/2
// - filter code 10 passes lines unfiltered; software avoids code 11
// - bit 28 picks encoder line sync (1) or output-stage line sync (0)
// - frame sync pulse resets encoder timing per policy in bits 27:24
// - policy 0000 resets every odd field, 0010 every even field
// - policy 0101 resets once at next odd field, then reads 0100
// - policy 0111 resets once at next even field, then reads 0110
// - policy 1000/1010 resets once per programmed number of odd/even fields
// - policy 1110 resets every field; software avoids other codes
// - bits 15:12 hold frames between resets minus one
// - interval bits only matter under policy 1000 or 1010
// - bit 11 adds sixteen frames to the interval
`timescale 1ns/1ns
`default_nettype none
module trc_ctrl
    import trc_pkg::*;
#(
    parameter int PIX_W = 8
) (
    input  wire logic              i_clk,         // pixel clock, 10 MHz
    input  wire logic              i_rst,         // sync reset, high
    input  wire logic [ADDR_W-1:0] i_addr,        // register byte address
    input  wire logic [31:0]       i_wdata,       // write data
    input  wire logic              i_wr,          // write strobe
    input  wire logic              i_rd,          // read strobe
    output logic      [31:0]       o_rdata,       // read data, next cycle
    input  wire logic              i_vsync,       // frame sync, async
    input  wire logic              i_field_odd,   // field parity, async
    input  wire logic              i_hsync_out,   // output-stage line sync
    input  wire logic              i_hsync_enc,   // encoder line sync
    output logic                   o_hsync_ref,   // chosen line sync
    output logic                   o_enc_reset,   // encoder timing reset
    input  wire logic [PIX_W-1:0]  i_pix_above,   // sample, line above
    input  wire logic [PIX_W-1:0]  i_pix_cur,     // sample, current line
    input  wire logic [PIX_W-1:0]  i_pix_below,   // sample, line below
    output logic      [PIX_W-1:0]  o_pix          // filtered sample
);
    if (PIX_W < 2 || PIX_W > 16) begin : g_bad_pix_w
        $error("trc_ctrl: PIX_W out of range");
    end

    typedef struct packed {
        logic [1:0]  filt;
        logic        href;
        logic [3:0]  policy;
        logic [4:0]  rsvd;
        logic [15:0] lo;
        logic [4:0]  cnt;
        logic        prev_vs;
        logic        enc_rst;
        logic        hs_ref;
        logic [7:0]  nres;
        logic [31:0] rdata;
    } trc_ctrl_s;

    trc_ctrl_s   q;
    trc_ctrl_s   next_q;
    logic [1:0]  sync_q;
    logic        vs_s;
    logic        odd_s;
    logic        rise;
    logic [4:0]  term;
    logic        periodic;
    logic        step;
    logic        hit;
    logic        wr_ctrl;

    trc_pix_if #(.W(PIX_W)) pif ();

    trc_sync2 #(
        .W (2)
    ) u_sync (
        .i_clk (i_clk),
        .i_rst (i_rst),
        .i_d   ({i_vsync, i_field_odd}),
        .o_q   (sync_q)
    );

    trc_flicker u_flt (
        .i_clk (i_clk),
        .i_rst (i_rst),
        .pif   (pif.filt)
    );

    assign vs_s  = sync_q[1];
    assign odd_s = sync_q[0];

    assign pif.mode  = q.filt;
    assign pif.above = i_pix_above;
    assign pif.cur   = i_pix_cur;
    assign pif.below = i_pix_below;

    // frames between resets, minus one, with optional sixteen added
    function automatic logic [4:0] interval_term(input logic [15:0] lo);
        logic [4:0] base;
        base = {1'b0, lo[IVAL_LSB+3:IVAL_LSB]};
        return base + (lo[P16_BIT] ? PLUS16 : 5'h00);
    endfunction

    // read view of the control word; reserved 31 and 23:21 read zero
    function automatic logic [31:0] ctrl_word(input trc_ctrl_s s);
        return {1'b0, s.filt, s.href, s.policy, 3'b000, s.rsvd, s.lo};
    endfunction

    assign rise     = vs_s & ~q.prev_vs;
    assign term     = interval_term(q.lo);
    assign wr_ctrl  = i_wr && (i_addr == CTRL_OFS);
    assign periodic = (q.policy == POL_PER_ODD) || (q.policy == POL_PER_EVN);

    // which field edges count toward and end the periodic interval
    always_comb begin
        step = 1'b0;
        hit  = 1'b0;
        unique case (q.policy)
            POL_ODD:      hit = odd_s;
            POL_EVEN:     hit = ~odd_s;
            POL_ONE_ODD:  hit = odd_s;
            POL_ONE_EVN:  hit = ~odd_s;
            POL_PER_ODD: begin
                step = odd_s;
                hit  = odd_s && (q.cnt >= term);
            end
            POL_PER_EVN: begin
                step = ~odd_s;
                hit  = ~odd_s && (q.cnt >= term);
            end
            POL_EVERY:    hit = 1'b1;
            // spent one-shots and reserved codes never reset
            default: begin
                step = 1'b0;
                hit  = 1'b0;
            end
        endcase
    end

    always_comb begin
        next_q         = q;
        next_q.prev_vs = vs_s;
        next_q.enc_rst = 1'b0;
        next_q.hs_ref  = q.href ? i_hsync_enc : i_hsync_out;

        if (rise) begin
            if (hit) begin
                next_q.enc_rst = 1'b1;
                next_q.cnt     = 5'h00;
                next_q.nres    = q.nres + 8'h01;
                if (q.policy == POL_ONE_ODD) begin
                    next_q.policy = POL_DONE_ODD;
                end
                if (q.policy == POL_ONE_EVN) begin
                    next_q.policy = POL_DONE_EVN;
                end
            end else if (step) begin
                next_q.cnt = q.cnt + 5'h01;
            end
        end

        // interval state is meaningless outside the periodic codes
        if (!periodic) begin
            next_q.cnt = 5'h00;
        end

        // a write lands after the hardware update, so a rearm wins
        if (wr_ctrl) begin
            next_q.filt   = i_wdata[FILT_LSB+1:FILT_LSB];
            next_q.href   = i_wdata[HREF_BIT];
            next_q.policy = i_wdata[POL_LSB+3:POL_LSB];
            next_q.rsvd   = i_wdata[RSVD_LSB+4:RSVD_LSB];
            next_q.lo     = i_wdata[15:0];
            next_q.cnt    = 5'h00;
        end

        next_q.rdata = 32'h00000000;
        if (i_rd) begin
            if (i_addr == CTRL_OFS) begin
                next_q.rdata = ctrl_word(q);
            end else if (i_addr == STAT_OFS) begin
                next_q.rdata[ST_CNT_LSB+4:ST_CNT_LSB]   = q.cnt;
                next_q.rdata[ST_ODD_BIT]                = odd_s;
                next_q.rdata[ST_VS_BIT]                 = vs_s;
                next_q.rdata[ST_NRES_LSB+7:ST_NRES_LSB] = q.nres;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            q        <= '0;
            q.filt   <= CTRL_RESET[FILT_LSB+1:FILT_LSB];
            q.href   <= CTRL_RESET[HREF_BIT];
            q.policy <= CTRL_RESET[POL_LSB+3:POL_LSB];
            q.rsvd   <= CTRL_RESET[RSVD_LSB+4:RSVD_LSB];
            q.lo     <= CTRL_RESET[15:0];
        end else begin
            q <= next_q;
        end
    end

    assign o_rdata     = q.rdata;
    assign o_hsync_ref = q.hs_ref;
    assign o_enc_reset = q.enc_rst;
    assign o_pix       = pif.result;

    AST_ODD_EVERY: assert property (@(posedge i_clk) disable iff (i_rst)
        (q.policy == POL_ODD && rise && odd_s) |=> o_enc_reset)
        else $error("odd field did not reset encoder");

    AST_EVEN_EVERY: assert property (@(posedge i_clk) disable iff (i_rst)
        (q.policy == POL_EVEN && rise) |=> (o_enc_reset == !$past(odd_s)))
        else $error("even policy reset on wrong field");

    AST_ONE_ODD: assert property (@(posedge i_clk) disable iff (i_rst)
        (q.policy == POL_ONE_ODD && rise && odd_s && !wr_ctrl)
        |=> o_enc_reset && q.policy == POL_DONE_ODD
        ##1 !o_enc_reset [*3])
        else $error("one-shot odd did not fire once and retire");

    AST_ONE_EVN: assert property (@(posedge i_clk) disable iff (i_rst)
        (q.policy == POL_ONE_EVN && rise && !odd_s && !wr_ctrl)
        |=> o_enc_reset && q.policy == POL_DONE_EVN)
        else $error("one-shot even did not fire and retire");

    AST_SPENT_QUIET: assert property (@(posedge i_clk) disable iff (i_rst)
        (q.policy == POL_DONE_ODD || q.policy == POL_DONE_EVN) |=> !o_enc_reset)
        else $error("spent one-shot reset the encoder");

    AST_EVERY: assert property (@(posedge i_clk) disable iff (i_rst)
        (q.policy == POL_EVERY && rise) |=> o_enc_reset)
        else $error("every-field policy missed a field");

    AST_ONLY_ON_SYNC: assert property (@(posedge i_clk) disable iff (i_rst)
        !rise |=> !o_enc_reset)
        else $error("encoder reset without a frame sync edge");

    AST_HREF: assert property (@(posedge i_clk) disable iff (i_rst)
        ##1 o_hsync_ref == ($past(q.href) ? $past(i_hsync_enc) : $past(i_hsync_out)))
        else $error("line sync reference not the selected source");

    AST_PER_FIRE: assert property (@(posedge i_clk) disable iff (i_rst)
        (q.policy == POL_PER_ODD && rise && odd_s && q.cnt == term) |=> o_enc_reset)
        else $error("periodic odd reset missed its interval");

    AST_PLUS16: assert property (@(posedge i_clk) disable iff (i_rst)
        (periodic && q.lo[P16_BIT] && q.cnt < PLUS16) |=> !o_enc_reset)
        else $error("plus sixteen interval ended early");

    AST_IGNORE_IVAL: assert property (@(posedge i_clk) disable iff (i_rst)
        !periodic |-> q.cnt == 5'h00)
        else $error("interval counter ran outside periodic policy");

    AST_RESTART: assert property (@(posedge i_clk) disable iff (i_rst)
        o_enc_reset |-> q.cnt == 5'h00)
        else $error("frame count not restarted at encoder reset");

    AST_INTERVAL: assert property (@(posedge i_clk) disable iff (i_rst)
        (periodic && rise && step && q.cnt < term) |=> !o_enc_reset)
        else $error("periodic reset before interval elapsed");

    AST_WR_FILT: assert property (@(posedge i_clk) disable iff (i_rst)
        wr_ctrl
        |=> q.filt == $past(i_wdata[FILT_LSB+1:FILT_LSB]))
        else $error("written filter code not applied");

    AST_WR_HREF: assert property (@(posedge i_clk) disable iff (i_rst)
        wr_ctrl
        |=> q.href == $past(i_wdata[HREF_BIT]))
        else $error("written line sync select not applied");

    AST_WR_POLICY: assert property (@(posedge i_clk) disable iff (i_rst)
        wr_ctrl
        |=> q.policy == $past(i_wdata[POL_LSB+3:POL_LSB]))
        else $error("written resync policy not applied");

    AST_WR_CLEAR: assert property (@(posedge i_clk) disable iff (i_rst)
        wr_ctrl
        |=> q.cnt == 5'h00)
        else $error("control write did not restart the frame count");

    AST_PULSE_ONE: assert property (@(posedge i_clk) disable iff (i_rst)
        o_enc_reset
        |=> !o_enc_reset)
        else $error("encoder reset longer than one cycle");

    AST_NRES: assert property (@(posedge i_clk) disable iff (i_rst)
        o_enc_reset
        |-> q.nres == $past(q.nres) + 8'h01)
        else $error("reset counter missed an encoder reset");

    AST_ODD_SKIP: assert property (@(posedge i_clk) disable iff (i_rst)
        (q.policy == POL_ODD && rise && !odd_s)
        |=> !o_enc_reset)
        else $error("odd policy reset on an even field");

    AST_ONE_ODD_WAIT: assert property (@(posedge i_clk) disable iff (i_rst)
        (q.policy == POL_ONE_ODD && rise && !odd_s)
        |=> !o_enc_reset)
        else $error("one-shot odd fired on an even field");

    AST_ONE_ODD_HOLD: assert property (@(posedge i_clk) disable iff (i_rst)
        (q.policy == POL_ONE_ODD && !(rise && odd_s) && !wr_ctrl)
        |=> q.policy == POL_ONE_ODD)
        else $error("one-shot odd retired before its reset");

    AST_ONE_EVN_WAIT: assert property (@(posedge i_clk) disable iff (i_rst)
        (q.policy == POL_ONE_EVN && rise && odd_s)
        |=> !o_enc_reset)
        else $error("one-shot even fired on an odd field");

    AST_ONE_EVN_HOLD: assert property (@(posedge i_clk) disable iff (i_rst)
        (q.policy == POL_ONE_EVN && !(rise && !odd_s) && !wr_ctrl)
        |=> q.policy == POL_ONE_EVN)
        else $error("one-shot even retired before its reset");

    AST_PER_EVN_FIRE: assert property (@(posedge i_clk) disable iff (i_rst)
        (q.policy == POL_PER_EVN && rise && !odd_s && q.cnt == term)
        |=> o_enc_reset)
        else $error("periodic even reset missed its interval");

    AST_PER_PARITY: assert property (@(posedge i_clk) disable iff (i_rst)
        (periodic && rise && (odd_s ^ (q.policy == POL_PER_ODD)))
        |=> !o_enc_reset)
        else $error("periodic reset on the wrong field parity");

    AST_CNT_STEP: assert property (@(posedge i_clk) disable iff (i_rst)
        (periodic && rise && step && q.cnt < term && !wr_ctrl)
        |=> q.cnt == $past(q.cnt) + 5'h01)
        else $error("matching field not counted");

    AST_CNT_BOUND: assert property (@(posedge i_clk) disable iff (i_rst)
        periodic
        |-> q.cnt <= term)
        else $error("frame count ran past the interval");

    AST_RESERVED_QUIET: assert property (@(posedge i_clk) disable iff (i_rst)
        !(q.policy inside {POL_ODD, POL_EVEN, POL_ONE_ODD, POL_ONE_EVN,
                           POL_PER_ODD, POL_PER_EVN, POL_EVERY})
        |=> !o_enc_reset)
        else $error("spent or reserved policy reset the encoder");

endmodule // trc_ctrl
`default_nettype wire

// File: verilog/trc_pkg.sv
/*
 * trc_pkg: register map, field positions, resync policy codes and
 * filter modes of the tv encoder field resync control block.
 * assumes a byte-addressed register port with 12 address bits.
 */
`default_nettype none
package trc_pkg;
    localparam int          ADDR_W      = 12;
    localparam logic [11:0] CTRL_OFS    = 12'h814;
    localparam logic [11:0] STAT_OFS    = 12'h820;
    localparam logic [31:0] CTRL_RESET  = 32'h00000000;
    // field positions of the control word
    localparam int FILT_LSB  = 29;
    localparam int HREF_BIT  = 28;
    localparam int POL_LSB   = 24;
    localparam int RSVD_LSB  = 16;
    localparam int IVAL_LSB  = 12;
    localparam int P16_BIT   = 11;
    // value software is expected to keep in bits 20:16
    localparam logic [4:0] RSVD_VALUE = 5'h02;
    localparam logic [4:0] PLUS16     = 5'h10;
    // status word positions
    localparam int ST_CNT_LSB = 0;
    localparam int ST_ODD_BIT = 5;
    localparam int ST_VS_BIT  = 6;
    localparam int ST_NRES_LSB = 8;
    localparam int SYNC_STAGES = 2;

    typedef enum logic [3:0] {
        POL_ODD      = 4'h0,
        POL_EVEN     = 4'h2,
        POL_DONE_ODD = 4'h4,
        POL_ONE_ODD  = 4'h5,
        POL_DONE_EVN = 4'h6,
        POL_ONE_EVN  = 4'h7,
        POL_PER_ODD  = 4'h8,
        POL_PER_EVN  = 4'ha,
        POL_EVERY    = 4'he
    } trc_policy_e;

    typedef enum logic [1:0] {
        FILT_QUARTER = 2'h0,
        FILT_HALF    = 2'h1,
        FILT_OFF     = 2'h2,
        FILT_RSVD    = 2'h3
    } trc_filt_e;
endpackage
`default_nettype wire

// File: verilog/trc_pix_if.sv
/*
 * trc_pix_if: carries filter mode and three vertical neighbour
 * samples from the control block to the flicker filter, and the result back.
 * assumes both ends run on the same encoder pixel clock.
 */
`timescale 1ns/1ns
`default_nettype none
interface trc_pix_if #(parameter int W = 8);
    logic [1:0]   mode;
    logic [W-1:0] above;
    logic [W-1:0] cur;
    logic [W-1:0] below;
    logic [W-1:0] result;
    modport ctrl (output mode, above, cur, below, input result);
    modport filt (input mode, above, cur, below, output result);
endinterface
`default_nettype wire

// File: verilog/trc_sync2.sv
/*
 * trc_sync2: two-flop synchroniser for level inputs from another domain.
 * assumes the inputs are slow levels; no pulse shorter than two clocks.
 */
`timescale 1ns/1ns
`default_nettype none
module trc_sync2 #(
    parameter int W = 2
) (
    input  wire logic         i_clk,  // pixel clock
    input  wire logic         i_rst,  // sync reset, high
    input  wire logic [W-1:0] i_d,    // async levels
    output logic      [W-1:0] o_q     // synchronised levels
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } trc_sync_s;
    trc_sync_s q;
    trc_sync_s next_q;
    if (W < 1) begin : g_bad_w
        $error("trc_sync2: W must be at least 1");
    end
    // first stage feeds only the second
    always_comb begin
        next_q    = q;
        next_q.s1 = i_d;
        next_q.s2 = q.s1;
    end
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end
    assign o_q = q.s2;
endmodule // trc_sync2
`default_nettype wire

// File: verilog/trc_flicker.sv
/*
 * trc_flicker: three-tap vertical flicker filter, one registered result.
 * assumes the caller supplies the samples of three adjacent lines.
 */
`timescale 1ns/1ns
`default_nettype none
module trc_flicker
    import trc_pkg::*;
(
    input  wire logic i_clk,  // pixel clock
    input  wire logic i_rst,  // sync reset, high
    trc_pix_if.filt   pif     // mode, samples, result
);
    localparam int W = $bits(pif.cur);
    typedef struct packed {
        logic [W-1:0] pix;
    } trc_flt_s;
    trc_flt_s   q;
    trc_flt_s   next_q;
    logic [W+1:0] sum;
    logic [W+1:0] half;
    assign sum  = {2'b00, pif.above} + {1'b0, pif.cur, 1'b0} + {2'b00, pif.below};
    assign half = sum >> 1;
    always_comb begin
        next_q = q;
        unique case (trc_filt_e'(pif.mode))
            FILT_QUARTER: next_q.pix = sum[W+1:2];
            // unity centre weight can exceed full scale, so saturate
            FILT_HALF:    next_q.pix = (half[W+1:W] != 2'b00) ?
                                       {W{1'b1}} : half[W-1:0];
            FILT_OFF:     next_q.pix = pif.cur;
            FILT_RSVD:    next_q.pix = pif.cur;
        endcase
    end
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end
    assign pif.result = q.pix;

    AST_FILT_QUARTER: assert property (@(posedge i_clk) disable iff (i_rst)
        pif.mode == FILT_QUARTER |=> pif.result == $past(sum[W+1:2]))
        else $error("quarter filter result wrong");
    AST_FILT_OFF: assert property (@(posedge i_clk) disable iff (i_rst)
        pif.mode == FILT_OFF |=> pif.result == $past(pif.cur))
        else $error("bypass did not pass the centre line");
    AST_FILT_HALF: assert property (@(posedge i_clk) disable iff (i_rst)
        (pif.mode == FILT_HALF && half[W+1:W] == 2'b00)
        |=> pif.result == $past(half[W-1:0]))
        else $error("half filter result wrong");
endmodule // trc_flicker
`default_nettype wire

// File: dv/trc_gdc_model.sv
/*
 * trc_gdc_model: display controller stand-in, sends a burst of fields
 * with frame sync and alternating parity, always starting on odd.
 * assumes the same pixel clock as the block; sync reset, active high.
 */
`timescale 1ns/1ns
`default_nettype none
module trc_gdc_model #(
    parameter int FIELD_LEN = 16
) (
    input  wire logic       i_clk,        // pixel clock
    input  wire logic       i_rst,        // sync reset, high
    input  wire logic       i_go,         // start a burst, one cycle
    input  wire logic [7:0] i_fields,     // fields in the burst
    output logic            o_vsync,      // frame sync
    output logic            o_field_odd,  // field parity
    output logic            o_busy        // burst running
);
    logic [7:0] left;
    logic [7:0] ph;

    // parity changes three cycles before the sync rise, so it is settled
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            left        <= 8'h00;
            ph          <= 8'h00;
            o_vsync     <= 1'b0;
            o_field_odd <= 1'b0;
        end else if (i_go) begin
            left        <= i_fields;
            ph          <= 8'h00;
            o_field_odd <= 1'b1;
        end else if (left != 8'h00) begin
            o_vsync <= (ph >= 8'h02) && (ph < 8'h06);
            if (ph == 8'(FIELD_LEN - 1)) begin
                ph   <= 8'h00;
                left <= left - 8'h01;
                if (left > 8'h01) begin
                    o_field_odd <= ~o_field_odd;
                end
            end else begin
                ph <= ph + 8'h01;
            end
        end else begin
            o_vsync <= 1'b0;
        end
    end

    assign o_busy = (left != 8'h00);
endmodule // trc_gdc_model
`default_nettype wire

// File: dv/trc_ctrl_test.sv
/*
 * trc_ctrl_test: register, line sync select, filter and resync policy
 * tests for trc_ctrl, with a display controller model on the sync side.
 * assumes the 10 MHz pixel clock and the one-cycle register port.
 */
`timescale 1ns/1ns
`default_nettype none
module trc_ctrl_test;
    import trc_pkg::*;
    logic              i_clk = 1'b0;
    logic              i_rst = 1'b1;
    logic [ADDR_W-1:0] i_addr = '0;
    logic [31:0]       i_wdata = '0;
    logic              i_wr = 1'b0;
    logic              i_rd = 1'b0;
    logic [31:0]       o_rdata;
    logic              vsync;
    logic              field_odd;
    logic              i_hsync_out = 1'b0;
    logic              i_hsync_enc = 1'b0;
    logic              o_hsync_ref;
    logic              o_enc_reset;
    logic [7:0]        pa = '0;
    logic [7:0]        pc = '0;
    logic [7:0]        pb = '0;
    logic [7:0]        o_pix;
    logic              go = 1'b0;
    logic [7:0]        nfields = '0;
    logic              busy;
    int                num_errors = 0;
    int                n_tests = 0;
    int                n_res = 0;
    logic [31:0]       d;

    always #50 i_clk = ~i_clk;

    trc_ctrl #(.PIX_W(8)) i_trc_ctrl (
        .i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_vsync(vsync),
        .i_field_odd(field_odd), .i_hsync_out(i_hsync_out),
        .i_hsync_enc(i_hsync_enc), .o_hsync_ref(o_hsync_ref),
        .o_enc_reset(o_enc_reset), .i_pix_above(pa), .i_pix_cur(pc),
        .i_pix_below(pb), .o_pix(o_pix)
    );

    trc_gdc_model #(.FIELD_LEN(16)) i_trc_gdc_model (
        .i_clk(i_clk), .i_rst(i_rst), .i_go(go), .i_fields(nfields),
        .o_vsync(vsync), .o_field_odd(field_odd), .o_busy(busy)
    );

    always @(posedge i_clk) begin
        if (o_enc_reset === 1'b1) begin
            n_res <= n_res + 1;
        end
    end

    task automatic close_out;
        $display("counts: %0d compares, %0d errors", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            $display("ERROR %0t: %s got %h exp %h", $time, what, got, exp);
            num_errors++;
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] w);
        @(posedge i_clk);
        i_wr    <= 1'b1;
        i_addr  <= a;
        i_wdata <= w;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [11:0] a, output logic [31:0] r);
        @(posedge i_clk);
        i_rd   <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        @(negedge i_clk);
        r = o_rdata;
    endtask

    // bits 20:16 always carry the value 2, as software must keep them
    function automatic logic [31:0] mk(input logic [1:0] f, input logic h,
                                       input logic [3:0] p, input logic [3:0] iv,
                                       input logic p16);
        return {1'b0, f, h, p, 3'h0, RSVD_VALUE, iv, p16, 11'h000};
    endfunction

    task automatic run_fields(input logic [7:0] n);
        int k;
        n_res = 0;
        @(posedge i_clk);
        go      <= 1'b1;
        nfields <= n;
        @(posedge i_clk);
        go <= 1'b0;
        // busy only rises once the model has taken the start strobe
        @(negedge i_clk);
        k = 0;
        while (busy !== 1'b0 && k < 5000) begin
            @(posedge i_clk);
            k++;
        end
        if (k >= 5000) begin
            check(32'h1, 32'h0, "field burst hang");
        end
        repeat (6) @(posedge i_clk);
    endtask

    // write (optional), send n fields, count resets, read the policy back
    task automatic pol_case(input logic [3:0] p, input logic [3:0] iv, input logic p16,
                            input logic [7:0] n, input logic w, input int exp_n,
                            input logic [3:0] exp_p);
        if (w) begin
            wr(CTRL_OFS, mk(2'h0, 1'b1, p, iv, p16));
            rd(CTRL_OFS, d);
            check(32'(d[27:24]), 32'(p), "policy before fields");
        end
        run_fields(n);
        check(32'(n_res), 32'(exp_n), "encoder reset count");
        rd(CTRL_OFS, d);
        check(32'(d[27:24]), 32'(exp_p), "policy readback");
        $display("test policy %h interval %h plus16 %b done", p, iv, p16);
    endtask

    task automatic filt_case(input logic [1:0] f, input logic [7:0] exp);
        wr(CTRL_OFS, mk(f, 1'b0, 4'h0, 4'h0, 1'b0));
        @(posedge i_clk);
        pa <= 8'h40;
        pc <= 8'h80;
        pb <= 8'h20;
        repeat (3) @(posedge i_clk);
        check(32'(o_pix), 32'(exp), "filter output");
        $display("test filter mode %h done", f);
    endtask

    initial begin
        repeat (16) @(posedge i_clk);
        i_rst <= 1'b0;
        rd(CTRL_OFS, d);
        check(d, CTRL_RESET, "control reset value");
        // legal codes only, reserved field kept at 2
        wr(CTRL_OFS, 32'h5e02_f800);
        rd(CTRL_OFS, d);
        check(d, 32'h5e02_f800, "control readback");
        wr(12'h818, 32'h0000_0000);
        rd(CTRL_OFS, d);
        check(d, 32'h5e02_f800, "unmapped write leaked");
        rd(12'h818, d);
        check(d, 32'h0000_0000, "unmapped read");
        $display("test registers done");

        wr(CTRL_OFS, mk(2'h0, 1'b0, 4'h0, 4'h0, 1'b0));
        @(posedge i_clk);
        i_hsync_out <= 1'b1;
        i_hsync_enc <= 1'b0;
        repeat (3) @(posedge i_clk);
        check(32'(o_hsync_ref), 32'h1, "line sync from output stage");
        wr(CTRL_OFS, mk(2'h0, 1'b1, 4'h0, 4'h0, 1'b0));
        repeat (3) @(posedge i_clk);
        check(32'(o_hsync_ref), 32'h0, "line sync from encoder");
        $display("test line sync select done");

        filt_case(2'h0, 8'h58);
        filt_case(2'h1, 8'hb0);
        filt_case(2'h2, 8'h80);

        pol_case(4'h0, 4'h0, 1'b0, 8'd8, 1'b1, 4, 4'h0);
        pol_case(4'h2, 4'h0, 1'b0, 8'd8, 1'b1, 4, 4'h2);
        pol_case(4'h5, 4'h0, 1'b0, 8'd8, 1'b1, 1, 4'h4);
        pol_case(4'h5, 4'h0, 1'b0, 8'd8, 1'b0, 0, 4'h4);
        pol_case(4'h7, 4'h0, 1'b0, 8'd8, 1'b1, 1, 4'h6);
        pol_case(4'h7, 4'h0, 1'b0, 8'd8, 1'b0, 0, 4'h6);
        pol_case(4'h8, 4'h1, 1'b0, 8'd8, 1'b1, 2, 4'h8);
        pol_case(4'ha, 4'h0, 1'b0, 8'd8, 1'b1, 4, 4'ha);
        pol_case(4'he, 4'h0, 1'b0, 8'd8, 1'b1, 8, 4'he);
        pol_case(4'h0, 4'hf, 1'b1, 8'd8, 1'b1, 4, 4'h0);
        pol_case(4'h8, 4'h0, 1'b1, 8'd32, 1'b1, 0, 4'h8);
        pol_case(4'h8, 4'h0, 1'b1, 8'd34, 1'b1, 1, 4'h8);
        rd(STAT_OFS, d);
        check(d, 32'h0000_1d00, "status after bursts");
        $display("test status done");
        close_out();
    end

    // tests need about 2600 cycles; allow ample margin
    initial begin
        repeat (20000) @(posedge i_clk);
        num_errors++;
        $display("ERROR %0t: watchdog expired", $time);
        close_out();
    end
endmodule // trc_ctrl_test
`default_nettype wire
